// ===== dv/mbpc_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbpc_map.vh"
// port-level checks of the bus and pin core
module mbpc_core_monitor #(
  parameter DW = 8,
  parameter DWD = 3,
  parameter NP = 3*DW+DWD
) (
  input wire logic          core_clk,
  input wire logic          srst,
  input wire logic          ce,
  input wire logic [2:0]    bus_mode,
  input wire logic [1:0]    rd_assign,
  input wire logic          address_strobe,
  input wire logic          ctrl_in_one,
  input wire logic [7:0]    addr_data_port_in,
  input wire logic [7:0]    addr_data_port_out,
  input wire logic          addr_data_port_oe,
  input wire logic [3:0]    burst_addr,
  input wire logic          resource_hit,
  input wire logic          reg_sel,
  input wire logic [1:0]    reg_port,
  input wire logic [2:0]    reg_kind,
  input wire logic [19:0]   host_addr,
  input wire logic          odd_byte,
  input wire logic          host_rd,
  input wire logic          host_wr,
  input wire logic [7:0]    host_wdata,
  input wire logic          ext_rd_strobe,
  input wire logic [NP-1:0] pt_oe,
  input wire logic [NP-1:0] pin_in,
  input wire logic [NP-1:0] pin_oe
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  odd_byte_a: assert property (odd_byte == host_addr[0])
    else $error("odd byte flag differs from address bit 0");
  pt_enable_a: assert property ((pt_oe[NP-1:8] & ~pin_oe[NP-1:8]) == '0)
    else $error("product term enable not reaching pin");
  reset_idle_a: assert property ($fell(srst) |-> pin_oe == pt_oe)
    else $error("pins driven after reset");
  addr_data_port_drive_a: assert property (addr_data_port_oe |-> host_rd &&
    (resource_hit || reg_sel) && bus_mode != `MBPC_BUS_NONMUX8)
    else $error("shared lines driven outside a selected read");
  ext_read_a: assert property (rd_assign == `MBPC_RD_SINGLE &&
    bus_mode != `MBPC_BUS_ESTROBE && !resource_hit && !ctrl_in_one |-> ext_rd_strobe)
    else $error("external read strobe missing");
  burst_low_a: assert property (bus_mode == `MBPC_BUS_BURST |->
    host_addr[3:0] == burst_addr)
    else $error("burst low address not from dedicated lines");
  page_hold_a: assert property (bus_mode == `MBPC_BUS_PAGE && $stable(bus_mode) &&
    !address_strobe && !$past(address_strobe) |-> $stable(host_addr[15:8]))
    else $error("page upper address moved without strobe");
  wdata_a: assert property (bus_mode == `MBPC_BUS_MUX8 && host_wr && ce |=>
    host_wdata == $past(addr_data_port_in))
    else $error("write data not taken from shared lines");
  single_rd_a: assert property (rd_assign == `MBPC_RD_SINGLE &&
    bus_mode != `MBPC_BUS_ESTROBE |-> host_rd == (!ctrl_in_one && resource_hit))
    else $error("single read strobe mapping wrong");
  pin_rb_a: assert property (reg_sel && host_rd && ce && reg_port == `MBPC_PORT_A &&
    reg_kind == `MBPC_RB_PIN ##1 reg_sel && host_rd |-> addr_data_port_out == $past(pin_in[7:0]))
    else $error("pin readback wrong");
endmodule
bind mbpc_core mbpc_core_monitor #(.DW(DW), .DWD(DWD)) u_mon (.*);
`default_nettype wire

// ===== dv/mbpc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbpc_map.vh"
module mbpc_core_tb;
  logic        core_clk, srst, ce, high_byte_enable, resource_hit, reg_sel, imc_use_pt, oe;
  logic [2:0]  bus_mode, reg_kind, ecs, e;
  logic [1:0]  rd_assign, reg_port, ext_addr_port, imc_mode;
  logic [3:0]  burst_addr;
  logic [7:0]  addr_hi_in, mem_rdata, q;
  logic [5:0]  imc_pt;
  logic [26:0] mcell, pt_oe, pin_in;
  logic [53:0] src_cfg;
  logic [12:0] rb_tab [7];
  wire         address_strobe, ctrl_in_zero, ctrl_in_one, ctrl_in_two, addr_data_port_oe;
  wire         odd_byte, host_rd, host_wr, ext_rd_strobe, ext_wr_strobe;
  wire  [7:0]  addr_data_port_in, addr_data_port_out, host_wdata;
  wire  [19:0] host_addr;
  wire  [26:0] pin_out, pin_oe;
  wire  [23:0] imc_out;
  int          n_mismatch = 0, tests_run = 0, cyc = 0;
  mbpc_core dut (.*);
  mbpc_host host (.*);
  // 50 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      conclude;
    end
  end
  // compare seen against expected
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task conclude;
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // port register access with the window selected
  task acc(input logic w, input logic [1:0] p, input logic [2:0] k, input logic [7:0] d);
    {reg_sel, resource_hit, reg_port, reg_kind} = {2'h3, p, k};
    if (w)
      host.wr(d);
    else
      host.rd(q, oe);
    {reg_sel, resource_hit} = 2'h0;
  endtask
  // main sequence
  initial
  begin
    {srst, ce, high_byte_enable, resource_hit, reg_sel, imc_use_pt} = 6'h30;
    {bus_mode, rd_assign, reg_kind, reg_port, ext_addr_port, imc_mode} = 14'h0;
    {burst_addr, mem_rdata, imc_pt, ecs, mcell, src_cfg} = 102'h0;
    {addr_hi_in, pt_oe, pin_in} = {8'h12, 27'h1000100, 27'h05a3ca6};
    rb_tab = '{13'h00c3, 13'h0100, 13'h025a, 13'h03ff, 13'h0477, 13'h0577, 13'h1300};
    repeat (8) @(posedge core_clk);
    #1;
    srst = 1'b0;
    chk(pin_oe, pt_oe);
    chk(imc_out, 24'h5a3ca6);
    host.adr(8'h35);
    chk(host_addr[15:0], 16'h1235);
    for (int m = 1; m < 3; m++)
    begin
      imc_mode = m[1:0];
      pin_in = {19'h0, m[7:0]};
      host.adr(8'h35);
      pin_in = 27'h0;
      host.strb(3'h7, 8'h00);
      chk(imc_out[7:0], m[7:0]);
    end
    imc_use_pt = 1'b1;
    pin_in = 27'h0000077;
    imc_pt = 6'h03;
    host.strb(3'h7, 8'h00);
    chk(imc_out[7:0], 8'h77);
    acc(1'b1, `MBPC_PORT_A, `MBPC_RB_DIR, 8'h5a);
    chk(pin_oe[7:0], 8'h5a);
    acc(1'b1, `MBPC_PORT_A, `MBPC_RB_DOUT, 8'hc3);
    chk(pin_out[7:0] & 8'h5a, 8'h42);
    acc(1'b1, `MBPC_PORT_A, `MBPC_RB_CTRL, 8'hff);
    chk(pin_out[7:0] & 8'h5a, 8'h10);
    {ecs, mcell, src_cfg} = {3'h5, 27'h0a50000, 6'h3f, 16'haaaa, 32'h0};
    host.strb(3'h7, 8'h00);
    chk(pin_out[26:16], {3'h5, 8'ha5});
    acc(1'b1, `MBPC_PORT_C, `MBPC_RB_CTRL, 8'hff);
    foreach (rb_tab[i])
    begin
      acc(1'b0, rb_tab[i][12:11], rb_tab[i][10:8], 8'h00);
      chk({oe, q}, {1'b1, rb_tab[i][7:0]});
    end
    // each read strobe under each assignment, with and without a hit
    for (int r = 0; r < 3; r++)
      for (int c = 0; c < 4; c++)
      begin
        rd_assign = r[1:0];
        resource_hit = c[1];
        e = (c[0] || r != 1) ? (c[1] ? 3'h5 : 3'h2) : 3'h0;
        host.strb(c[0] ? 3'h5 : 3'h3, 8'h00);
        chk({host_rd, ext_rd_strobe, addr_data_port_oe}, e);
      end
    for (int h = 0; h < 2; h++)
    begin
      resource_hit = h[0];
      host.strb(3'h6, 8'h00);
      chk({host_wr, ext_wr_strobe}, h ? 2'h2 : 2'h1);
    end
    bus_mode = `MBPC_BUS_ESTROBE;
    rd_assign = `MBPC_RD_THREE;
    for (int c = 1; c < 4; c++)
    begin
      host.strb({1'b1, c[1:0]}, 8'h00);
      chk({host_rd, host_wr}, {c == 3, c == 2});
    end
    bus_mode = `MBPC_BUS_BURST;
    host.strb(3'h7, 8'h00);
    host.adr(8'h9a);
    for (int i = 0; i < 16; i++)
    begin
      burst_addr = i[3:0];
      @(posedge core_clk) #1;
      chk(host_addr[11:0], {8'h9a, i[3:0]});
    end
    bus_mode = `MBPC_BUS_PAGE;
    host.adr(8'h7e);
    high_byte_enable = 1'b1;
    host.strb(3'h7, 8'h81);
    chk(host_addr[15:8], 8'h7e);
    chk(host_addr[7:0], 8'h81);
    // idle then selected read on the separate data port
    bus_mode = `MBPC_BUS_NONMUX8;
    pin_in = 27'h00309a6;
    mem_rdata = 8'hd2;
    for (int i = 0; i < 2; i++)
    begin
      ext_addr_port = 2'h1 + i[1:0];
      resource_hit = i[0];
      host.strb(i[0] ? 3'h5 : 3'h7, 8'h44 | i[7:0]);
      chk({host_addr[19:16], host_addr[7:0]}, {i[0] ? 4'h3 : 4'h9, 8'h44 | i[7:0]});
      chk(odd_byte, i[0]);
      chk({pin_oe[7:0], addr_data_port_oe}, {i[0] ? 8'hff : 8'h00, 1'b0});
      chk(pin_out[7:0], 8'hd2);
    end
    conclude;
  end
endmodule
`default_nettype wire

// ===== dv/mbpc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the bus: control strobes active low, address strobe active high, lines turned over when the address or write strobe is released
module mbpc_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] addr_data_port_out,
  input  wire logic       addr_data_port_oe,
  output var  logic       address_strobe = 1'b0,
  output var  logic       ctrl_in_zero = 1'b1,
  output var  logic       ctrl_in_one = 1'b1,
  output var  logic       ctrl_in_two = 1'b1,
  output wire logic [7:0] addr_data_port_in
);
  logic [7:0] hv = 8'h00;
  // shared lines: the device wins while it drives them
  assign addr_data_port_in = addr_data_port_oe ? addr_data_port_out : hv;
  // address phase of one strobe cycle, then lines inverted
  task adr(input logic [7:0] a);
    @(posedge core_clk) #1;
    address_strobe = 1'b1;
    hv = a;
    @(posedge core_clk) #1;
    address_strobe = 1'b0;
    hv = ~a;
  endtask
  // write: strobe and data held over two edges
  task wr(input logic [7:0] d);
    @(posedge core_clk) #1;
    ctrl_in_zero = 1'b0;
    hv = d;
    repeat (2) @(posedge core_clk);
    #1;
    ctrl_in_zero = 1'b1;
    hv = ~d;
  endtask
  // read: answer settled after the first strobe edge, released after the second
  task rd(output logic [7:0] q, output logic oe);
    @(posedge core_clk) #1;
    ctrl_in_one = 1'b0;
    hv = ~hv;
    @(posedge core_clk) #1;
    q = addr_data_port_out;
    oe = addr_data_port_oe;
    @(posedge core_clk) #1;
    ctrl_in_one = 1'b1;
  endtask
  // raw strobe levels {two, one, zero} and line value
  task strb(input logic [2:0] c, input logic [7:0] a);
    @(posedge core_clk) #1;
    {ctrl_in_two, ctrl_in_one, ctrl_in_zero} = c;
    hv = a;
    #1;
  endtask
endmodule
`default_nettype wire

// ===== rtl/mbpc_core.v
// Summary of operation
// - address strobe optional on non-mux bus; latches low address on mux bus
// - non-mux bus: address on addr_data_port, data on port A, undriven idle
// - above sixteen address bits, ports B/C/D supply upper address inputs
// - address bit 0 picks even/odd byte; high byte enable ignored
// - fetch, read, write strobes on control inputs 2,1,0 all access resources
// - single-read configurations: fetch strobe on control input 1 is the read
// - fourth configuration: read on input 1, fetch on input 2, both read
// - non-page mode: data shares low address byte, strobe every cycle
// - page mode: data shares upper byte; page hit reuses latched upper address
// - page mode access timed from low byte valid, no strobe setup needed
// - burst: upper bits held while four low lines fetch sixteen bytes
// - burst host 8-bit: bits 11..4 multiplexed, bits 3..0 dedicated
// - enable strobe with read/write line; decode gives external rd/wr strobes
// - four ports: A, B, C eight bits, D three bits, each pin configurable
// - pin mux: data-out, latched address, macrocell, external chip selects
// - readback buffer drives exactly one source onto internal data bus
// - pin driver enable is product term OR direction bit
// - no product term and not logic output: direction bit alone enables
// - ports A,B,C input macrocells: latch, register or pass-through
// - macrocell gate from address strobe or product term
// - programmed modes fixed; control/direction/data-out writable at run time
// - mux bus: drive address/data lines only when selected and reading
// - control bit 0 gives host I/O mode, data-out drives output pin
// - direction bit 1 output, 0 input
`timescale 1ns/1ps
`default_nettype none
`include "mbpc_map.vh"
module mbpc_core #(
  parameter DW = 8,
  parameter DWD = 3
) (
  input  wire           core_clk,
  input  wire           srst,
  input  wire           ce,
  input  wire [2:0]     bus_mode,
  input  wire [1:0]     rd_assign,
  input  wire           address_strobe,
  input  wire           ctrl_in_zero,
  input  wire           ctrl_in_one,
  input  wire           ctrl_in_two,
  input  wire           high_byte_enable,
  input  wire [7:0]     addr_data_port_in,
  output reg  [7:0]     addr_data_port_out,
  output wire           addr_data_port_oe,
  input  wire [3:0]     burst_addr,
  input  wire [7:0]     addr_hi_in,
  input  wire           resource_hit,
  input  wire [7:0]     mem_rdata,
  input  wire           reg_sel,
  input  wire [1:0]     reg_port,
  input  wire [2:0]     reg_kind,
  input  wire [1:0]     ext_addr_port,
  output wire [19:0]    host_addr,
  output wire           odd_byte,
  output wire           host_rd,
  output wire           host_wr,
  output reg  [7:0]     host_wdata,
  output wire           ext_rd_strobe,
  output wire           ext_wr_strobe,
  input  wire [3*DW+DWD-1:0] mcell,
  input  wire [3*DW+DWD-1:0] pt_oe,
  input  wire [2*(3*DW+DWD)-1:0] src_cfg,
  input  wire [2:0]     ecs,
  input  wire [1:0]     imc_mode,
  input  wire           imc_use_pt,
  input  wire [5:0]     imc_pt,
  input  wire [3*DW+DWD-1:0] pin_in,
  output wire [3*DW+DWD-1:0] pin_out,
  output wire [3*DW+DWD-1:0] pin_oe,
  output wire [3*DW-1:0] imc_out
);
  localparam NP = 3*DW+DWD;
  reg  [7:0]    lat_lo;
  reg  [7:0]    lat_hi;
  reg  [7:0]    lat_ext;
  reg  [NP-1:0] dout;
  reg  [NP-1:0] dir;
  reg  [2*DW-1:0] ctrl;
  reg  [7:0]    rb_data;
  reg           rd_act;
  reg           wr_act;
  reg  [7:0]    a_lo;
  reg  [7:0]    a_hi;
  wire          nonmux;
  wire [7:0]    ext_field;
  wire [NP-1:0] lat_addr;
  wire [NP-1:0] ecs_v;
  wire [NP-1:0] has_ctrl;
  wire [NP-1:0] port_oe;
  wire [NP-1:0] port_out;
  wire [7:0]    pa_data;

  // field of a port-wide vector, D zero-padded
  function [7:0] port_field;
    input [NP-1:0] v;
    input [1:0]    p;
    begin
      case (p)
        `MBPC_PORT_A: port_field = v[DW-1:0];
        `MBPC_PORT_B: port_field = v[2*DW-1:DW];
        `MBPC_PORT_C: port_field = v[3*DW-1:2*DW];
        default:      port_field = {{(8-DWD){1'b0}}, v[NP-1:3*DW]};
      endcase
    end
  endfunction

  assign nonmux = (bus_mode == `MBPC_BUS_NONMUX8);
  // strobe decode per configuration; control inputs active low, except the enable on input 1, active high in the enable-strobe mode
  always @*
  begin
    case (bus_mode)
      `MBPC_BUS_ESTROBE:
      begin
        rd_act = ctrl_in_one & ctrl_in_zero;
        wr_act = ctrl_in_one & ~ctrl_in_zero;
      end
      default:
      begin
        rd_act = (rd_assign == `MBPC_RD_SINGLE) ? ~ctrl_in_one :
                 (~ctrl_in_one | ~ctrl_in_two);
        wr_act = ~ctrl_in_zero;
      end
    endcase
  end
  assign host_rd = rd_act & resource_hit;
  assign host_wr = wr_act & resource_hit;
  assign ext_rd_strobe = rd_act & ~resource_hit;
  assign ext_wr_strobe = wr_act & ~resource_hit;

  // address latch on strobe; page hit keeps upper byte
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      lat_lo  <= `MBPC_ZERO8;
      lat_hi  <= `MBPC_ZERO8;
      lat_ext <= `MBPC_ZERO8;
    end
    else if (ce && address_strobe && !nonmux)
    begin
      if (bus_mode == `MBPC_BUS_PAGE)
        lat_hi <= addr_data_port_in;
      else
        lat_lo <= addr_data_port_in;
      lat_hi  <= (bus_mode == `MBPC_BUS_PAGE) ? addr_data_port_in : addr_hi_in;
      lat_ext <= port_field(pin_in, ext_addr_port);
    end
  end
  // live address assembly per bus mode
  always @*
  begin
    case (bus_mode)
      `MBPC_BUS_NONMUX8:
      begin
        a_lo = addr_data_port_in;
        a_hi = addr_hi_in;
      end
      `MBPC_BUS_PAGE:
      begin
        a_lo = addr_data_port_in;
        a_hi = lat_hi;
      end
      `MBPC_BUS_BURST:
      begin
        a_lo = {lat_lo[`MBPC_BURST_LSB-1:0], burst_addr};
        a_hi = {4'h0, lat_lo[7:`MBPC_BURST_LSB]};
      end
      default:
      begin
        a_lo = lat_lo;
        a_hi = addr_hi_in;
      end
    endcase
  end
  // upper nibble: live on the non-mux bus, latched otherwise
  assign ext_field = port_field(pin_in, ext_addr_port);
  assign host_addr = {(nonmux ? ext_field[3:0] : lat_ext[3:0]), a_hi, a_lo};
  assign odd_byte = host_addr[0]; // high_byte_enable unused

  // write data capture from shared lines or port A
  assign pa_data = pin_in[DW-1:0];
  always @(posedge core_clk)
  begin
    if (srst)
      host_wdata <= `MBPC_ZERO8;
    else if (ce && wr_act)
      host_wdata <= nonmux ? pa_data : addr_data_port_in;
  end

  // run-time port registers; programmed modes come in as inputs
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      dout <= {NP{1'b0}};
      dir  <= {NP{1'b0}};
      ctrl <= {2*DW{1'b0}};
    end
    else if (ce && host_wr && reg_sel)
    begin
      case (reg_kind)
        `MBPC_RB_DOUT:
          case (reg_port)
            `MBPC_PORT_A: dout[DW-1:0] <= host_wdata;
            `MBPC_PORT_B: dout[2*DW-1:DW] <= host_wdata;
            `MBPC_PORT_C: dout[3*DW-1:2*DW] <= host_wdata;
            default:      dout[NP-1:3*DW] <= host_wdata[DWD-1:0];
          endcase
        `MBPC_RB_DIR:
          case (reg_port)
            `MBPC_PORT_A: dir[DW-1:0] <= host_wdata;
            `MBPC_PORT_B: dir[2*DW-1:DW] <= host_wdata;
            `MBPC_PORT_C: dir[3*DW-1:2*DW] <= host_wdata;
            default:      dir[NP-1:3*DW] <= host_wdata[DWD-1:0];
          endcase
        `MBPC_RB_CTRL:
          if (reg_port == `MBPC_PORT_A)
            ctrl[DW-1:0] <= host_wdata;
          else if (reg_port == `MBPC_PORT_B)
            ctrl[2*DW-1:DW] <= host_wdata;
        default: ;
      endcase
    end
  end

  // readback buffer: one source at a time
  always @*
  begin
    case (reg_kind)
      `MBPC_RB_DOUT:  rb_data = port_field(dout, reg_port);
      `MBPC_RB_MCELL: rb_data = port_field(mcell, reg_port);
      `MBPC_RB_DIR:   rb_data = port_field(dir, reg_port);
      `MBPC_RB_CTRL:  rb_data = (reg_port[1]) ? `MBPC_ZERO8 :
                                port_field({{(NP-2*DW){1'b0}}, ctrl}, reg_port);
      `MBPC_RB_IMC:   rb_data = (reg_port == `MBPC_PORT_D) ? `MBPC_ZERO8 :
                                port_field({{DWD{1'b0}}, imc_out}, reg_port);
      default:        rb_data = port_field(pin_in, reg_port);
    endcase
  end
  // returned data register
  always @(posedge core_clk)
  begin
    if (srst)
      addr_data_port_out <= `MBPC_ZERO8;
    else if (ce)
      addr_data_port_out <= reg_sel ? rb_data : mem_rdata;
  end
  assign addr_data_port_oe = host_rd & ~nonmux;

  // pin helpers: latched address on A/B, chip selects on D
  assign lat_addr = {{(NP-DW){1'b0}}, a_lo} |
                    {{(NP-2*DW){1'b0}}, (bus_mode == `MBPC_BUS_PAGE) ? lat_hi : a_lo,
                     {DW{1'b0}}};
  assign ecs_v    = {ecs, {(3*DW){1'b0}}};
  assign has_ctrl = {{(NP-2*DW){1'b0}}, {(2*DW){1'b1}}};
  // port A is the data port on non-mux bus, undriven unless read
  assign pin_oe   = nonmux ? {port_oe[NP-1:DW], {DW{host_rd}}} : port_oe;
  assign pin_out  = nonmux ? {port_out[NP-1:DW], addr_data_port_out} : port_out;

  // ports A-C with macrocells, D without
  mbpc_pin_slice #(.WIDTH(3*DW)) u_abc (
    .core_clk       (core_clk),
    .srst           (srst),
    .ce             (ce),
    .dout           (dout[3*DW-1:0]),
    .dir            (dir[3*DW-1:0]),
    .ctrl           ({{DW{1'b0}}, ctrl}),
    .lat_addr       (lat_addr[3*DW-1:0]),
    .mcell          (mcell[3*DW-1:0]),
    .ecs            (ecs_v[3*DW-1:0]),
    .src_cfg        (src_cfg[6*DW-1:0]),
    .has_ctrl       (has_ctrl[3*DW-1:0]),
    .pt_oe          (pt_oe[3*DW-1:0]),
    .pin_in         (pin_in[3*DW-1:0]),
    .imc_mode       (imc_mode),
    .imc_use_pt     (imc_use_pt),
    .imc_pt         (imc_pt),
    .address_strobe (address_strobe),
    .pin_out        (port_out[3*DW-1:0]),
    .pin_oe         (port_oe[3*DW-1:0]),
    .imc_q          (imc_out)
  );
  mbpc_pin_slice #(.WIDTH(DWD)) u_d (
    .core_clk       (core_clk),
    .srst           (srst),
    .ce             (ce),
    .dout           (dout[NP-1:3*DW]),
    .dir            (dir[NP-1:3*DW]),
    .ctrl           ({DWD{1'b0}}),
    .lat_addr       ({DWD{1'b0}}),
    .mcell          (mcell[NP-1:3*DW]),
    .ecs            (ecs_v[NP-1:3*DW]),
    .src_cfg        (src_cfg[2*NP-1:6*DW]),
    .has_ctrl       ({DWD{1'b0}}),
    .pt_oe          (pt_oe[NP-1:3*DW]),
    .pin_in         (pin_in[NP-1:3*DW]),
    .imc_mode       (`MBPC_IMC_PASS),
    .imc_use_pt     (1'b0),
    .imc_pt         (1'b0),
    .address_strobe (1'b0),
    .pin_out        (port_out[NP-1:3*DW]),
    .pin_oe         (port_oe[NP-1:3*DW]),
    .imc_q          ()
  );
endmodule
`default_nettype wire

// ===== rtl/mbpc_map.vh
`ifndef MBPC_MAP_VH
`define MBPC_MAP_VH
// host bus configurations
`define MBPC_BUS_MUX8      3'h0
`define MBPC_BUS_NONMUX8   3'h1
`define MBPC_BUS_PAGE      3'h2
`define MBPC_BUS_BURST     3'h3
`define MBPC_BUS_ESTROBE   3'h4
// read strobe assignment
`define MBPC_RD_THREE      2'h0
`define MBPC_RD_SINGLE     2'h1
`define MBPC_RD_DUAL       2'h2
// pin output source select
`define MBPC_SRC_DOUT      2'h0
`define MBPC_SRC_ADDR      2'h1
`define MBPC_SRC_MCELL     2'h2
`define MBPC_SRC_ECS       2'h3
// readback source select
`define MBPC_RB_DOUT       3'h0
`define MBPC_RB_MCELL      3'h1
`define MBPC_RB_DIR        3'h2
`define MBPC_RB_CTRL       3'h3
`define MBPC_RB_PIN        3'h4
`define MBPC_RB_IMC        3'h5
// input macrocell modes
`define MBPC_IMC_PASS      2'h0
`define MBPC_IMC_LATCH     2'h1
`define MBPC_IMC_REG       2'h2
// port selects, reset values and burst address split
`define MBPC_PORT_A        2'h0
`define MBPC_PORT_B        2'h1
`define MBPC_PORT_C        2'h2
`define MBPC_PORT_D        2'h3
`define MBPC_ZERO8         8'h00
`define MBPC_BURST_LSB     4
`endif

// ===== rtl/mbpc_pin_slice.v
`timescale 1ns/1ps
`default_nettype none
`include "mbpc_map.vh"
// a slice of pins (ports A-C or port D): output mux, enable, input macrocell
module mbpc_pin_slice #(
  parameter WIDTH = 8
) (
  input  wire             core_clk,
  input  wire             srst,
  input  wire             ce,
  input  wire [WIDTH-1:0] dout,
  input  wire [WIDTH-1:0] dir,
  input  wire [WIDTH-1:0] ctrl,
  input  wire [WIDTH-1:0] lat_addr,
  input  wire [WIDTH-1:0] mcell,
  input  wire [WIDTH-1:0] ecs,
  input  wire [2*WIDTH-1:0] src_cfg,
  input  wire [WIDTH-1:0] has_ctrl,
  input  wire [WIDTH-1:0] pt_oe,
  input  wire [WIDTH-1:0] pin_in,
  input  wire [1:0]       imc_mode,
  input  wire             imc_use_pt,
  input  wire [(WIDTH+3)/4-1:0] imc_pt,
  input  wire             address_strobe,
  output wire [WIDTH-1:0] pin_out,
  output wire [WIDTH-1:0] pin_oe,
  output reg  [WIDTH-1:0] imc_q
);
  // one gate per group of four pins
  localparam NG = (WIDTH+3)/4;
  reg  [WIDTH-1:0] imc_hold;
  reg  [NG-1:0]    gate_prev;
  wire [NG-1:0]    gate;
  genvar i;
  // latch enable / clock from address strobe or product term per nibble
  assign gate = imc_use_pt ? imc_pt : {NG{address_strobe}};
  always @(posedge core_clk)
  begin
    if (srst)
      gate_prev <= {NG{1'b0}};
    else if (ce)
      gate_prev <= gate;
  end
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_pin
      wire [1:0] sel;
      wire       g;
      wire       rise;
      assign g    = gate[i/4];
      assign rise = g & ~gate_prev[i/4];
      // ctrl bit picks source on A/B, programmed choice elsewhere
      assign sel = has_ctrl[i] ? (ctrl[i] ? `MBPC_SRC_ADDR : `MBPC_SRC_DOUT)
                               : src_cfg[2*i+1:2*i];
      assign pin_out[i] = (sel == `MBPC_SRC_DOUT) ? dout[i] :
                          (sel == `MBPC_SRC_ADDR) ? lat_addr[i] :
                          (sel == `MBPC_SRC_MCELL) ? mcell[i] : ecs[i];
      // driver enable: product term OR direction bit
      assign pin_oe[i] = pt_oe[i] | dir[i];
      // input macrocell: latch, register or pass
      always @(posedge core_clk)
      begin
        if (srst)
          imc_hold[i] <= 1'b0;
        else if (ce && ((imc_mode == `MBPC_IMC_LATCH && g) ||
                        (imc_mode == `MBPC_IMC_REG && rise)))
          imc_hold[i] <= pin_in[i];
      end
      always @*
      begin
        if (imc_mode == `MBPC_IMC_PASS)
          imc_q[i] = pin_in[i];
        else if (imc_mode == `MBPC_IMC_LATCH && g)
          imc_q[i] = pin_in[i];
        else
          imc_q[i] = imc_hold[i];
      end
    end
  endgenerate
endmodule
`default_nettype wire
